// >>> logic/tlr_mode_router.sv
// mode dependent clock, trigger, sync and latency routing
`timescale 1ns/100ps
module tlr_mode_router
#(
   parameter int WORD_W  = 16,
   parameter int SUP_W   = 8,
   parameter int LAT_W   = 12,
   parameter int LAT_MAX = tlr_pkg::LAT_MAX_RST
)
(
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic [1:0]               mode_cfg,
   input  wire logic                     slave_port_b,
   input  wire logic                     local_clk_copper,
   input  wire logic                     local_trig_fp,
   input  wire logic [tlr_pkg::DIV_W-1:0] clk_div_n,
   input  wire logic [SUP_W-1:0]         sup_cfg,
   input  wire logic [WORD_W-1:0]        gen_word,
   input  wire logic [WORD_W-1:0]        fp_word,
   input  wire logic [WORD_W-1:0]        rx_word_a,
   input  wire logic [WORD_W-1:0]        rx_word_b,
   input  wire logic                     sync_gen,
   input  wire logic                     sync_rx_a,
   input  wire logic                     sync_rx_b,
   input  wire logic                     meas_rx_a,
   input  wire logic                     meas_rx_b,
   input  wire logic                     meas_start,
   output logic [1:0]                    mode_out,
   output logic [tlr_pkg::CLK_SRC_W-1:0] clk_src_sel,
   output logic                          clk_tx_a,
   output logic                          clk_tx_b,
   output logic [WORD_W-1:0]             tx_word_a,
   output logic [WORD_W-1:0]             tx_word_b,
   output logic [WORD_W-1:0]             trig_word,
   output logic                          trig_word_stb,
   output logic                          sync_tx_a,
   output logic                          sync_tx_b,
   output logic                          sync_out,
   output logic                          meas_tx_a,
   output logic                          meas_tx_b,
   output logic [LAT_W-1:0]              lat_val,
   output logic                          lat_valid,
   output logic                          lat_timeout,
   output logic                          clkout,
   output logic                          clkout_stb,
   output logic [SUP_W-1:0]              sup_cfg_eff
);

   tlr_pkg::tlr_mode_t mode_in;
   tlr_pkg::tlr_mode_t mode_r;
   tlr_pkg::tlr_mode_t mode_nxt;
   logic                          init_r;
   logic                          cfg_load;
   logic                          slave_b_r;
   logic                          slave_b_nxt;
   logic                          copper_r;
   logic                          copper_nxt;
   logic                          fp_r;
   logic                          fp_nxt;
   logic [tlr_pkg::CLK_SRC_W-1:0] clk_sel_r;
   logic [tlr_pkg::CLK_SRC_W-1:0] clk_sel_nxt;
   logic                          ctx_a_r;
   logic                          ctx_a_nxt;
   logic                          ctx_b_r;
   logic                          ctx_b_nxt;
   logic                          loop_a_r;
   logic                          loop_a_nxt;
   logic                          loop_b_r;
   logic                          loop_b_nxt;
   logic                          meas_en_r;
   logic                          meas_en_nxt;
   logic                          meas_b_r;
   logic                          meas_b_nxt;
   logic                          word_stb;
   logic                          local_mode;

   assign mode_in  = tlr_pkg::tlr_mode_t'(mode_cfg);
   assign cfg_load = !init_r || (mode_in != mode_r);

   // ****************************************************************
   // routing decode
   // ****************************************************************
   always_comb
   begin
      mode_nxt    = mode_r;
      slave_b_nxt = slave_b_r;
      copper_nxt  = copper_r;
      fp_nxt      = fp_r;
      if (cfg_load)
      begin
         mode_nxt    = mode_in;
         slave_b_nxt = slave_port_b;
         copper_nxt  = local_clk_copper;
         fp_nxt      = local_trig_fp;
      end
      clk_sel_nxt = '0;
      ctx_a_nxt   = 1'b0;
      ctx_b_nxt   = 1'b0;
      loop_a_nxt  = 1'b0;
      loop_b_nxt  = 1'b0;
      meas_en_nxt = 1'b0;
      meas_b_nxt  = 1'b0;
      case (mode_nxt)
         tlr_pkg::TLR_STANDALONE, tlr_pkg::TLR_MASTER:
         begin
            if (copper_nxt)
               clk_sel_nxt[tlr_pkg::CLK_SRC_COP] = 1'b1;
            else
               clk_sel_nxt[tlr_pkg::CLK_SRC_OSC] = 1'b1;
            ctx_a_nxt  = 1'b1;
            ctx_b_nxt  = 1'b1;
            loop_a_nxt = 1'b1;
            loop_b_nxt = 1'b1;
         end
         tlr_pkg::TLR_CHAIN:
         begin
            clk_sel_nxt[tlr_pkg::CLK_SRC_FA] = 1'b1;
            ctx_b_nxt   = 1'b1;
            loop_b_nxt  = 1'b1;
            meas_en_nxt = 1'b1;
         end
         tlr_pkg::TLR_SLAVE:
         begin
            if (slave_b_nxt)
               clk_sel_nxt[tlr_pkg::CLK_SRC_FB] = 1'b1;
            else
               clk_sel_nxt[tlr_pkg::CLK_SRC_FA] = 1'b1;
            meas_en_nxt = 1'b1;
            meas_b_nxt  = slave_b_nxt;
         end
         default:
            clk_sel_nxt[tlr_pkg::CLK_SRC_OSC] = 1'b1;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         init_r    <= 1'b0;
         mode_r    <= tlr_pkg::MODE_RST;
         slave_b_r <= 1'b0;
         copper_r  <= 1'b0;
         fp_r      <= 1'b0;
         clk_sel_r <= tlr_pkg::CLK_SRC_W'(1 << tlr_pkg::CLK_SRC_OSC);
         ctx_a_r   <= 1'b0;
         ctx_b_r   <= 1'b0;
         loop_a_r  <= 1'b0;
         loop_b_r  <= 1'b0;
         meas_en_r <= 1'b0;
         meas_b_r  <= 1'b0;
      end
      else
      begin
         init_r    <= 1'b1;
         mode_r    <= mode_nxt;
         slave_b_r <= slave_b_nxt;
         copper_r  <= copper_nxt;
         fp_r      <= fp_nxt;
         clk_sel_r <= clk_sel_nxt;
         ctx_a_r   <= ctx_a_nxt;
         ctx_b_r   <= ctx_b_nxt;
         loop_a_r  <= loop_a_nxt;
         loop_b_r  <= loop_b_nxt;
         meas_en_r <= meas_en_nxt;
         meas_b_r  <= meas_b_nxt;
      end
   end

   assign local_mode  = (mode_r == tlr_pkg::TLR_STANDALONE) || (mode_r == tlr_pkg::TLR_MASTER);
   assign mode_out    = mode_r;
   assign clk_src_sel = clk_sel_r;
   assign clk_tx_a    = ctx_a_r;
   assign clk_tx_b    = ctx_b_r;
   // supervisor settings read as zero outside the master role
   assign sup_cfg_eff = (mode_r == tlr_pkg::TLR_MASTER) ? sup_cfg : '0;

   // ****************************************************************
   // cadence and clock output
   // ****************************************************************
   tlr_clk_div u_div
   (
      .clk        (clk),
      .srst       (srst),
      .div_n      (clk_div_n),
      .word_stb   (word_stb),
      .clkout     (clkout),
      .clkout_stb (clkout_stb)
   );

   // ****************************************************************
   // trigger and sync paths
   // ****************************************************************
   logic [WORD_W-1:0] txa_r;
   logic [WORD_W-1:0] txa_nxt;
   logic [WORD_W-1:0] txb_r;
   logic [WORD_W-1:0] txb_nxt;
   logic [WORD_W-1:0] trw_r;
   logic [WORD_W-1:0] trw_nxt;
   logic [WORD_W-1:0] local_word;
   logic              trs_r;
   logic              sa_r;
   logic              sa_nxt;
   logic              sb_r;
   logic              sb_nxt;
   logic              so_r;
   logic              so_nxt;

   always_comb
   begin
      local_word = fp_r ? fp_word : gen_word;
      txa_nxt    = txa_r;
      txb_nxt    = txb_r;
      trw_nxt    = trw_r;
      sa_nxt     = 1'b0;
      sb_nxt     = 1'b0;
      case (mode_r)
         tlr_pkg::TLR_STANDALONE, tlr_pkg::TLR_MASTER:
         begin
            so_nxt = sync_gen;
            sa_nxt = sync_gen;
            sb_nxt = sync_gen;
         end
         tlr_pkg::TLR_CHAIN:
         begin
            so_nxt = sync_rx_a;
            sb_nxt = sync_rx_a;
         end
         tlr_pkg::TLR_SLAVE:
            so_nxt = slave_b_r ? sync_rx_b : sync_rx_a;
         default:
            so_nxt = 1'b0;
      endcase
      if (word_stb)
      begin
         txa_nxt = '0;
         txb_nxt = '0;
         case (mode_r)
            tlr_pkg::TLR_STANDALONE, tlr_pkg::TLR_MASTER:
            begin
               txa_nxt = local_word;
               txb_nxt = local_word;
               trw_nxt = local_word; // looped back to trigger this board too
            end
            tlr_pkg::TLR_CHAIN:
            begin
               txb_nxt = rx_word_a;
               trw_nxt = rx_word_a;
            end
            tlr_pkg::TLR_SLAVE:
               trw_nxt = slave_b_r ? rx_word_b : rx_word_a;
            default:
               trw_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         txa_r <= '0;
         txb_r <= '0;
         trw_r <= '0;
         trs_r <= 1'b0;
         sa_r  <= 1'b0;
         sb_r  <= 1'b0;
         so_r  <= 1'b0;
      end
      else
      begin
         txa_r <= txa_nxt;
         txb_r <= txb_nxt;
         trw_r <= trw_nxt;
         trs_r <= word_stb;
         sa_r  <= sa_nxt;
         sb_r  <= sb_nxt;
         so_r  <= so_nxt;
      end
   end

   assign tx_word_a     = txa_r;
   assign tx_word_b     = txb_r;
   assign trig_word     = trw_r;
   assign trig_word_stb = trs_r;
   assign sync_tx_a     = sa_r;
   assign sync_tx_b     = sb_r;
   assign sync_out      = so_r;

   // ****************************************************************
   // latency measurement pair
   // ****************************************************************
   tlr_pkg::tlr_lat_state_t lst_r;
   tlr_pkg::tlr_lat_state_t lst_nxt;
   logic [LAT_W-1:0] lcnt_r;
   logic [LAT_W-1:0] lcnt_nxt;
   logic [LAT_W-1:0] lval_r;
   logic [LAT_W-1:0] lval_nxt;
   logic             lvld_r;
   logic             lvld_nxt;
   logic             lto_r;
   logic             lto_nxt;
   logic             pulse;
   logic             mta_r;
   logic             mta_nxt;
   logic             mtb_r;
   logic             mtb_nxt;
   logic             rx_sel;

   assign rx_sel = meas_b_r ? meas_rx_b : meas_rx_a;

   always_comb
   begin
      lst_nxt  = lst_r;
      lcnt_nxt = lcnt_r;
      lval_nxt = lval_r;
      lvld_nxt = lvld_r;
      lto_nxt  = lto_r;
      pulse    = 1'b0;
      case (lst_r)
         tlr_pkg::TLR_LAT_IDLE:
            if (meas_start && meas_en_r)
            begin
               pulse    = 1'b1;
               lcnt_nxt = '0;
               lvld_nxt = 1'b0;
               lto_nxt  = 1'b0;
               lst_nxt  = tlr_pkg::TLR_LAT_WAIT;
            end
         tlr_pkg::TLR_LAT_WAIT:
         begin
            lcnt_nxt = lcnt_r + 1'b1;
            if (!meas_en_r)
               lst_nxt = tlr_pkg::TLR_LAT_IDLE;
            else if (rx_sel)
            begin
               lval_nxt = lcnt_r;
               lvld_nxt = 1'b1;
               lst_nxt  = tlr_pkg::TLR_LAT_IDLE;
            end
            else if (lcnt_r == LAT_W'(LAT_MAX))
            begin
               lto_nxt = 1'b1; // no echo: give up rather than hang
               lst_nxt = tlr_pkg::TLR_LAT_IDLE;
            end
         end
         default:
            lst_nxt = tlr_pkg::TLR_LAT_IDLE;
      endcase
      mta_nxt = loop_a_r ? meas_rx_a : (pulse && meas_en_r && !meas_b_r);
      mtb_nxt = loop_b_r ? meas_rx_b : (pulse && meas_en_r && meas_b_r);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lst_r  <= tlr_pkg::TLR_LAT_IDLE;
         lcnt_r <= '0;
         lval_r <= '0;
         lvld_r <= 1'b0;
         lto_r  <= 1'b0;
         mta_r  <= 1'b0;
         mtb_r  <= 1'b0;
      end
      else
      begin
         lst_r  <= lst_nxt;
         lcnt_r <= lcnt_nxt;
         lval_r <= lval_nxt;
         lvld_r <= lvld_nxt;
         lto_r  <= lto_nxt;
         mta_r  <= mta_nxt;
         mtb_r  <= mtb_nxt;
      end
   end

   assign meas_tx_a   = mta_r;
   assign meas_tx_b   = mtb_r;
   assign lat_val     = lval_r;
   assign lat_valid   = lvld_r;
   assign lat_timeout = lto_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_mode_apply: assert property (cfg_load |=> mode_out == $past(mode_cfg))
      else $error("mode not applied");
   a_local_clk: assert property (local_mode |->
      (clk_src_sel[tlr_pkg::CLK_SRC_FA] == 1'b0 && clk_src_sel[tlr_pkg::CLK_SRC_FB] == 1'b0))
      else $error("fiber clock used in local mode");
   a_local_trig: assert property ((local_mode && $stable(mode_r) && word_stb && !cfg_load)
      |=> trig_word == (fp_r ? $past(fp_word) : $past(gen_word)))
      else $error("local trigger source wrong");
   a_both_ports: assert property ((local_mode && $stable(mode_r) && word_stb && !cfg_load)
      |=> tx_word_a == tx_word_b && clk_tx_a && clk_tx_b)
      else $error("ports differ in local mode");
   a_chain_clk: assert property (mode_r == tlr_pkg::TLR_CHAIN |->
      clk_src_sel[tlr_pkg::CLK_SRC_FA] && clk_tx_b && !clk_tx_a)
      else $error("chain clock routing wrong");
   a_chain_fwd: assert property ((mode_r == tlr_pkg::TLR_CHAIN && $stable(mode_r)) |=>
      sync_tx_b == $past(sync_rx_a))
      else $error("chain sync not forwarded");
   a_loop_back: assert property (loop_b_r |=> meas_tx_b == $past(meas_rx_b))
      else $error("port b measurement not looped");
   a_slave_src: assert property (mode_r == tlr_pkg::TLR_SLAVE |->
      clk_src_sel[slave_b_r ? tlr_pkg::CLK_SRC_FB : tlr_pkg::CLK_SRC_FA] && meas_b_r == slave_b_r)
      else $error("slave source wrong");
   a_word_rate: assert property (trig_word_stb |=> !trig_word_stb [*3] ##1 trig_word_stb)
      else $error("trigger word cadence wrong");
   a_sup_gate: assert property (mode_r != tlr_pkg::TLR_MASTER |-> sup_cfg_eff == '0)
      else $error("supervisor settings leak");
   a_one_clock: assert property ($onehot(clk_src_sel))
      else $error("clock source not one-hot");
   a_route_hold: assert property ((init_r && !cfg_load) |=> $stable(clk_src_sel))
      else $error("routing moved without mode change");

   c_chain_mode: cover property (mode_r == tlr_pkg::TLR_CHAIN && trig_word_stb);
   c_slave_b:    cover property (mode_r == tlr_pkg::TLR_SLAVE && slave_b_r && lat_valid);
   c_timeout:    cover property ($rose(lat_timeout));
   c_mode_swap:  cover property (mode_r == tlr_pkg::TLR_MASTER ##1 cfg_load);

endmodule : tlr_mode_router

// >>> logic/tlr_pkg.sv
// shared constants and types of the trigger link mode router
// ****************************************************************
// What this block does
// - mode comes from clock settings, routing follows
// - master/standalone clock: oscillator or copper only
// - master/standalone triggers: generators or front panel
// - master/standalone: own sync, measurement pair looped
// - master/standalone: both ports send trigger, clock, sync
// - chain: clock from port A, forwarded on B
// - chain: trigger and sync A in, B out
// - chain: measure on A, loop B back
// - slave: clock from port A or B
// - slave: trigger, sync, measurement from clock port
// - one trigger word every four clock cycles
// - clock output is system clock over n for n 2..8, held high for n of 1
// - supervisor settings act only in master role
// - exactly one system clock source active
// - measurement pair looped in master and standalone; chain loops B and pulses A; slave pulses
// ****************************************************************
package tlr_pkg;

   // ****************************************************************
   // modes and sources
   // ****************************************************************
   typedef enum logic [1:0] {
      TLR_STANDALONE,
      TLR_MASTER,
      TLR_CHAIN,
      TLR_SLAVE
   } tlr_mode_t;

   typedef enum logic [0:0] {
      TLR_LAT_IDLE,
      TLR_LAT_WAIT
   } tlr_lat_state_t;

   // one-hot clock source select bit positions
   localparam int CLK_SRC_W    = 4;
   localparam int CLK_SRC_OSC  = 0;
   localparam int CLK_SRC_COP  = 1;
   localparam int CLK_SRC_FA   = 2;
   localparam int CLK_SRC_FB   = 3;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int SYS_PERIOD_NS  = 4;
   localparam int WORD_PERIOD_NS = 16;
   localparam int WORD_CYCLES    = WORD_PERIOD_NS / SYS_PERIOD_NS;
   localparam int WORD_CNT_W     = $clog2(WORD_CYCLES);
   localparam int DIV_W          = 4;
   localparam logic [DIV_W-1:0] DIV_MIN = 4'h1;
   localparam logic [DIV_W-1:0] DIV_MAX = 4'h8;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam tlr_mode_t MODE_RST = TLR_STANDALONE;
   localparam int        LAT_MAX_RST = 4000;

endpackage : tlr_pkg

// >>> logic/tlr_clk_div.sv
// word cadence strobe and divided clock output
`timescale 1ns/100ps
module tlr_clk_div
(
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic [tlr_pkg::DIV_W-1:0] div_n,
   output logic                          word_stb,
   output logic                          clkout,
   output logic                          clkout_stb
);

   logic [tlr_pkg::WORD_CNT_W-1:0] wcnt_r;
   logic [tlr_pkg::WORD_CNT_W-1:0] wcnt_nxt;
   logic [tlr_pkg::DIV_W-1:0]      dcnt_r;
   logic [tlr_pkg::DIV_W-1:0]      dcnt_nxt;
   logic [tlr_pkg::DIV_W-1:0]      n_r;
   logic [tlr_pkg::DIV_W-1:0]      n_nxt;
   logic [tlr_pkg::DIV_W-1:0]      n_clamp;
   logic                           stb_r;
   logic                           stb_nxt;
   logic                           ck_r;
   logic                           ck_nxt;
   logic                           wstb_r;
   logic                           wstb_nxt;

   // ****************************************************************
   // counters
   // ****************************************************************
   always_comb
   begin
      n_clamp = div_n;
      if (div_n < tlr_pkg::DIV_MIN)
         n_clamp = tlr_pkg::DIV_MIN;
      else if (div_n > tlr_pkg::DIV_MAX)
         n_clamp = tlr_pkg::DIV_MAX;
      wcnt_nxt = wcnt_r + 1'b1;
      wstb_nxt = (wcnt_r == tlr_pkg::WORD_CNT_W'(tlr_pkg::WORD_CYCLES - 1));
      n_nxt    = n_r;
      stb_nxt  = 1'b0;
      // new ratio only at a period boundary, so no runt pulse
      if (dcnt_r >= n_r - 1'b1)
      begin
         dcnt_nxt = '0;
         n_nxt    = n_clamp;
         stb_nxt  = 1'b1;
      end
      else
         dcnt_nxt = dcnt_r + 1'b1;
      // n of 1 cannot toggle at clock rate: held high, strobe every cycle
      ck_nxt = (dcnt_nxt < ((n_nxt + 1'b1) >> 1)) || (n_nxt == tlr_pkg::DIV_MIN);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wcnt_r <= '0;
         wstb_r <= 1'b0;
         dcnt_r <= '0;
         n_r    <= tlr_pkg::DIV_MIN;
         stb_r  <= 1'b0;
         ck_r   <= 1'b0;
      end
      else
      begin
         wcnt_r <= wcnt_nxt;
         wstb_r <= wstb_nxt;
         dcnt_r <= dcnt_nxt;
         n_r    <= n_nxt;
         stb_r  <= stb_nxt;
         ck_r   <= ck_nxt;
      end
   end

   assign word_stb   = wstb_r;
   assign clkout     = ck_r;
   assign clkout_stb = stb_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_div_in_range: assert property (dcnt_r < n_r && n_r >= tlr_pkg::DIV_MIN
      && n_r <= tlr_pkg::DIV_MAX)
      else $error("divider count out of range");
   a_div_fixed_n: assert property ((stb_r && n_r == 4'h3 && div_n == 4'h3) |=>
      !stb_r ##1 !stb_r ##1 stb_r)
      else $error("divide by three period wrong");

endmodule : tlr_clk_div

// >>> dv/tlr_echo_model.sv
// far end of the fiber latency pairs: returns each pulse after a fixed delay
`timescale 1ns/100ps
module tlr_echo_model
#(
   parameter int DLY = 6
)
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic echo_en,
   input  wire logic meas_tx_a,
   input  wire logic meas_tx_b,
   output logic      meas_rx_a,
   output logic      meas_rx_b
);
   logic [DLY-1:0] dly_a_r;
   logic [DLY-1:0] dly_b_r;
   // echo_en low models a broken fiber, so the pulse never returns
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         dly_a_r <= '0;
         dly_b_r <= '0;
      end
      else
      begin
         dly_a_r <= {dly_a_r[DLY-2:0], meas_tx_a & echo_en};
         dly_b_r <= {dly_b_r[DLY-2:0], meas_tx_b & echo_en};
      end
   end
   assign meas_rx_a = dly_a_r[DLY-1];
   assign meas_rx_b = dly_b_r[DLY-1];
endmodule : tlr_echo_model

// >>> dv/trigger_link_mode_router_bench.sv
// self-checking bench of the trigger link mode router
`timescale 1ns/100ps
module trigger_link_mode_router_bench;
   localparam int DLY = 6;
   logic        clk, srst, slave_port_b, local_clk_copper, local_trig_fp, echo_en;
   logic        sync_gen, sync_rx_a, sync_rx_b, meas_rx_a, meas_rx_b, meas_start;
   logic [1:0]  mode_cfg, mode_out;
   logic [3:0]  clk_div_n, clk_src_sel;
   logic [7:0]  sup_cfg, sup_cfg_eff;
   logic [15:0] gen_word, fp_word, rx_word_a, rx_word_b, tx_word_a, tx_word_b, trig_word;
   logic        clk_tx_a, clk_tx_b, trig_word_stb, sync_tx_a, sync_tx_b, sync_out;
   logic        meas_tx_a, meas_tx_b, lat_valid, lat_timeout, clkout, clkout_stb;
   logic [11:0] lat_val;
   int          n_mismatch, comparisons, i, k;

   tlr_mode_router #(.LAT_MAX(20)) uut (
      .clk(clk), .srst(srst), .mode_cfg(mode_cfg), .slave_port_b(slave_port_b),
      .local_clk_copper(local_clk_copper), .local_trig_fp(local_trig_fp),
      .clk_div_n(clk_div_n), .sup_cfg(sup_cfg), .gen_word(gen_word), .fp_word(fp_word),
      .rx_word_a(rx_word_a), .rx_word_b(rx_word_b), .sync_gen(sync_gen),
      .sync_rx_a(sync_rx_a), .sync_rx_b(sync_rx_b), .meas_rx_a(meas_rx_a),
      .meas_rx_b(meas_rx_b), .meas_start(meas_start), .mode_out(mode_out),
      .clk_src_sel(clk_src_sel), .clk_tx_a(clk_tx_a), .clk_tx_b(clk_tx_b),
      .tx_word_a(tx_word_a), .tx_word_b(tx_word_b), .trig_word(trig_word),
      .trig_word_stb(trig_word_stb), .sync_tx_a(sync_tx_a), .sync_tx_b(sync_tx_b),
      .sync_out(sync_out), .meas_tx_a(meas_tx_a), .meas_tx_b(meas_tx_b),
      .lat_val(lat_val), .lat_valid(lat_valid), .lat_timeout(lat_timeout),
      .clkout(clkout), .clkout_stb(clkout_stb), .sup_cfg_eff(sup_cfg_eff));

   tlr_echo_model #(.DLY(DLY)) far_end (
      .clk(clk), .srst(srst), .echo_en(echo_en), .meas_tx_a(meas_tx_a),
      .meas_tx_b(meas_tx_b), .meas_rx_a(meas_rx_a), .meas_rx_b(meas_rx_b));

   always #50 clk = ~clk;

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic finish_test;
      $display("compared %0d mismatched %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic hang(input string what);
      n_mismatch++;
      $display("BAD %s expected 1 seen timeout", what);
      finish_test();
   endtask : hang

   // routing latches only on the first cycle after reset or when the mode value changes
   task automatic set_cfg(input logic [1:0] m, input logic pb, input logic cp, input logic fp);
      @(negedge clk);
      mode_cfg = m;
      slave_port_b = pb;
      local_clk_copper = cp;
      local_trig_fp = fp;
      repeat (6) @(negedge clk);
   endtask : set_cfg

   task automatic wait_stb;
      for (k = 0; k < 8 && trig_word_stb !== 1'b1; k++) @(negedge clk);
      if (trig_word_stb !== 1'b1) hang("trig_word_stb");
   endtask : wait_stb

   task automatic measure(input logic [11:0] exp);
      meas_start = 1'b1;
      @(negedge clk);
      meas_start = 1'b0;
      for (k = 0; k < 40 && lat_valid !== 1'b1; k++) @(negedge clk);
      chk("lat_valid", 1, lat_valid);
      chk("lat_val", exp, lat_val);
   endtask : measure

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_local;
      set_cfg(2'h0, 1'b0, 1'b0, 1'b0);
      chk("osc sel", 4'h1, clk_src_sel);
      chk("clk tx", 2'h3, {clk_tx_a, clk_tx_b});
      wait_stb();
      chk("gen tx", 32'h12341234, {tx_word_a, tx_word_b});
      chk("gen loop", 16'h1234, trig_word);
      chk("own sync", 2'h3, {sync_tx_a, sync_tx_b});
      chk("sup off", 8'h00, sup_cfg_eff);
      set_cfg(2'h1, 1'b0, 1'b1, 1'b1);
      chk("mode", 2'h1, mode_out);
      chk("cop sel", 4'h2, clk_src_sel);
      wait_stb();
      chk("fp tx", 32'hABCDABCD, {tx_word_a, tx_word_b});
      chk("sup on", 8'h5A, sup_cfg_eff);
      for (i = 1; i <= 4; i++)
      begin
         @(negedge clk);
         chk("cadence", i == 4, trig_word_stb);
      end
      $display("test local done");
   endtask : t_local

   task automatic t_chain;
      set_cfg(2'h2, 1'b1, 1'b0, 1'b0);
      chk("chain sel", 4'h4, clk_src_sel);
      chk("chain clk tx", 2'h1, {clk_tx_a, clk_tx_b});
      wait_stb();
      chk("chain words", 32'h00000F0F, {tx_word_a, tx_word_b});
      chk("chain trig", 16'h0F0F, trig_word);
      chk("chain sync", 3'h3, {sync_tx_a, sync_tx_b, sync_out});
      measure(DLY);
      $display("test chain done");
   endtask : t_chain

   task automatic t_slave;
      set_cfg(2'h3, 1'b1, 1'b0, 1'b0);
      chk("slave sel", 4'h8, clk_src_sel);
      chk("slave clk tx", 2'h0, {clk_tx_a, clk_tx_b});
      wait_stb();
      chk("slave trig", 16'hF0F0, trig_word);
      chk("slave sync", 1'b0, sync_out);
      measure(DLY);
      slave_port_b = 1'b0;
      repeat (6) @(negedge clk);
      chk("no relatch", 4'h8, clk_src_sel);
      set_cfg(2'h2, 1'b0, 1'b0, 1'b0);
      echo_en = 1'b0;
      meas_start = 1'b1;
      @(negedge clk);
      meas_start = 1'b0;
      for (k = 0; k < 40 && lat_timeout !== 1'b1; k++) @(negedge clk);
      chk("timeout", 2'h2, {lat_timeout, lat_valid});
      set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
      chk("slave a sel", 4'h4, clk_src_sel);
      chk("slave a sync", 1'b1, sync_out);
      echo_en = 1'b1;
      measure(DLY);
      $display("test slave done");
   endtask : t_slave

   task automatic t_div;
      logic [3:0] ns [5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'hC};
      int         ex [5] = '{1, 1, 3, 8, 8};
      int         h;
      for (i = 0; i < 5; i++)
      begin
         clk_div_n = ns[i];
         repeat (20) @(negedge clk);
         for (k = 0; k < 12 && clkout_stb !== 1'b1; k++) @(negedge clk);
         k = 0;
         h = 0;
         do begin @(negedge clk); k++; h += clkout; end while (clkout_stb !== 1'b1 && k < 12);
         chk("div period", ex[i], k);
         chk("clkout high", (ex[i] + 1) / 2, h);
      end
      $display("test divider done");
   endtask : t_div

   initial
   begin
      clk = 1'b0; srst = 1'b1; mode_cfg = 2'h0; slave_port_b = 1'b0; echo_en = 1'b1;
      local_clk_copper = 1'b0; local_trig_fp = 1'b0; clk_div_n = 4'h1; sup_cfg = 8'h5A;
      gen_word = 16'h1234; fp_word = 16'hABCD; rx_word_a = 16'h0F0F; rx_word_b = 16'hF0F0;
      sync_gen = 1'b1; sync_rx_a = 1'b1; sync_rx_b = 1'b0; meas_start = 1'b0;
      n_mismatch = 0; comparisons = 0;
      repeat (4) @(negedge clk);
      chk("reset mode", 2'h0, mode_out);
      chk("reset sel", 4'h1, clk_src_sel);
      srst = 1'b0;
      t_local();
      t_chain();
      t_slave();
      t_div();
      finish_test();
   end
endmodule : trigger_link_mode_router_bench
